/* core/ecp_top.sv */
// Enhanced compare and PWM unit with its APB register slave.
`timescale 1ns/1ps
`default_nettype none
module ecp_top #(
  parameter int UNIT_INDEX = 1
) (
  input  wire logic              sys_clk_in,
  input  wire logic              rstn_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [7:0]        paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic              adc_enable_in,
  input  wire ecp_pkg::ecp_pins_t port_data_in,
  input  wire ecp_pkg::ecp_pins_t port_oe_n_in,
  output ecp_pkg::ecp_pins_t     pin_data_out,
  output ecp_pkg::ecp_pins_t     pin_oe_n_out,
  output logic                   unit4_override_out,
  output logic                   special_trigger_out,
  output logic                   adc_start_out,
  output logic                   update_tick_out
);
  import ecp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.

  ecp_ctrl_t   ctrl_reg;
  ecp_tctrl_t  tctrl_reg;
  logic [7:0]  duty_write_reg;
  logic [7:0]  duty_shadow_reg;
  logic [7:0]  period_reg;
  logic [6:0]  dband_reg;
  logic [15:0] cmp_val_reg;
  logic [15:0] tmr_first_reg;
  logic [15:0] tmr_third_reg;
  logic [2:0]  stat_reg;
  logic [7:0]  tbase_reg [2];
  logic [31:0] rdata_next;
  logic        hit;
  logic        wr_en;
  logic        pwm_mode;
  logic        cmp_mode;

  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = wr_en && (paddr_in == ofs);
  endfunction : wr_at

  assign wr_en    = psel_in && penable_in && pwrite_in;
  assign pwm_mode = (ctrl_reg.mode[3:2] == MODE_PWM_PFX);
  assign cmp_mode = (ctrl_reg.mode == MODE_CMP_SWI) || (ctrl_reg.mode == MODE_SPECIAL);

  always_comb begin
    hit        = 1'b1;
    rdata_next = 32'h0000_0000;
    case (paddr_in)
      OFS_CTRL:   rdata_next[7:0]  = ctrl_reg;
      OFS_DUTYW:  rdata_next[7:0]  = duty_write_reg;
      OFS_DUTYS:  rdata_next[7:0]  = duty_shadow_reg;
      OFS_PERIOD: rdata_next[7:0]  = period_reg;
      OFS_DBAND:  rdata_next[6:0]  = dband_reg;
      OFS_TCTRL:  rdata_next[7:0]  = tctrl_reg;
      OFS_CMPV:   rdata_next[15:0] = cmp_val_reg;
      OFS_TMRF:   rdata_next[15:0] = tmr_first_reg;
      OFS_TMRT:   rdata_next[15:0] = tmr_third_reg;
      OFS_STAT:   rdata_next[2:0]  = stat_reg;
      OFS_TBASE:  rdata_next[7:0]  = tbase_reg[tctrl_reg.pwm_sel];
      default:    hit              = 1'b0;
    endcase
  end

  // Read data and error are captured in the setup cycle and held for the access.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (psel_in && !penable_in) begin
      prdata_out  <= pwrite_in ? 32'h0000_0000 : rdata_next;
      pslverr_out <= !hit;
    end
  end

  assign pready_out = 1'b1;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_reg       <= CTRL_RST;
      tctrl_reg      <= TCTRL_RST;
      duty_write_reg <= 8'h00;
      period_reg     <= PERIOD_RST;
      dband_reg      <= 7'h00;
      cmp_val_reg    <= 16'h0000;
    end else begin
      if (wr_at(OFS_CTRL))   ctrl_reg       <= pwdata_in[7:0];
      if (wr_at(OFS_TCTRL))  tctrl_reg      <= pwdata_in[7:0];
      if (wr_at(OFS_DUTYW))  duty_write_reg <= pwdata_in[7:0];
      if (wr_at(OFS_PERIOD)) period_reg     <= pwdata_in[7:0];
      if (wr_at(OFS_DBAND))  dband_reg      <= pwdata_in[6:0];
      if (wr_at(OFS_CMPV))   cmp_val_reg    <= pwdata_in[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction-cycle divider, prescaler and the two PWM timebases.

  logic [1:0]  q_reg;
  logic [3:0]  pre_reg;
  logic        tcy_en;
  logic        pre_tick;
  logic [1:0]  fine_bits;
  logic [7:0]  tb_act;
  logic        period_end;
  logic [9:0]  fine_now;

  assign tcy_en = (q_reg == 2'h3);

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) q_reg <= 2'h0;
    else          q_reg <= q_reg + 2'h1;
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in)    pre_reg <= 4'h0;
    else if (tcy_en) pre_reg <= pre_reg + 4'h1;
  end

  // Timebase ticks once per instruction cycle times the prescale value.
  always_comb begin
    case (tctrl_reg.pre)
      PRE_1: begin
        pre_tick  = tcy_en;
        fine_bits = q_reg;
      end
      PRE_4: begin
        pre_tick  = tcy_en && (pre_reg[1:0] == 2'h3);
        fine_bits = pre_reg[1:0];
      end
      default: begin
        pre_tick  = tcy_en && (pre_reg == 4'hF);
        fine_bits = pre_reg[3:2];
      end
    endcase
  end

  assign tb_act     = tbase_reg[tctrl_reg.pwm_sel];
  assign period_end = pre_tick && (tb_act == period_reg);
  assign fine_now   = {tb_act, fine_bits};

  // Both timebases share one process so the array has a single driver.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tbase_reg[0] <= 8'h00;
      tbase_reg[1] <= 8'h00;
    end else if (pre_tick) begin
      for (int g = 0; g < 2; g++) begin
        if (tbase_reg[g] == period_reg) tbase_reg[g] <= 8'h00;
        else                            tbase_reg[g] <= tbase_reg[g] + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Postscaler, used only for the update tick.

  logic [3:0] post_reg;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      post_reg        <= 4'h0;
      update_tick_out <= 1'b0;
    end else begin
      update_tick_out <= 1'b0;
      if (period_end) begin
        if (post_reg == tctrl_reg.post) begin
          post_reg        <= 4'h0;
          update_tick_out <= 1'b1;
        end else begin
          post_reg <= post_reg + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Double-buffered PWM state and the raw waveform.

  logic [1:0] dlsb_latch;
  logic [1:0] cfg_sh;
  logic [1:0] pol_sh;
  logic       pwm_sh;
  logic       raw_reg;
  logic       raw_d;
  logic       raw_wave;
  logic       duty_hit;
  logic [6:0] db_work;
  logic [6:0] db_cnt;
  logic       db_clear;
  logic       pwm_act;

  // Equality at a fine count beyond the period never occurs, so no clear.
  assign duty_hit = ({duty_shadow_reg, dlsb_latch} == fine_now);
  assign pwm_act  = pwm_sh && pwm_mode;

  // The wave drops in the cycle of the match, so high time equals the duty count.
  assign raw_wave = raw_reg && !duty_hit;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      duty_shadow_reg <= 8'h00;
      dlsb_latch      <= 2'h0;
      cfg_sh          <= CFG_SINGLE;
      pol_sh          <= 2'h0;
      pwm_sh          <= 1'b0;
    end else if (period_end) begin
      duty_shadow_reg <= duty_write_reg;
      dlsb_latch      <= ctrl_reg.dlsb;
      cfg_sh          <= ctrl_reg.cfg;
      pol_sh          <= ctrl_reg.mode[1:0];
      pwm_sh          <= pwm_mode;
    end else if (wr_at(OFS_DUTYS) && !pwm_mode) begin
      duty_shadow_reg <= pwdata_in[7:0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      raw_reg <= 1'b0;
    end else if (period_end) begin
      raw_reg <= ({duty_write_reg, ctrl_reg.dlsb} != 10'h000);
    end else if (duty_hit) begin
      raw_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in)                    db_work <= 7'h00;
    else if (period_end || duty_hit) db_work <= dband_reg;
  end

  // Each edge of the raw wave restarts the count; either side turns on at zero.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      raw_d  <= 1'b0;
      db_cnt <= 7'h00;
    end else begin
      raw_d <= raw_wave;
      if (raw_wave != raw_d)              db_cnt <= db_work;
      else if (tcy_en && db_cnt != 7'h00) db_cnt <= db_cnt - 7'h01;
    end
  end

  // A zero delay must not cost the cycle in which the edge is seen.
  assign db_clear = (raw_wave == raw_d) ? (db_cnt == 7'h00) : (db_work == 7'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Output steering, one-instruction-cycle lag and pin drive.

  ecp_pins_t act_now;
  ecp_pins_t use_now;
  ecp_pins_t act_lag [LAG_DEPTH];
  ecp_pins_t use_lag [LAG_DEPTH];
  logic      ovr_lag [LAG_DEPTH];
  ecp_pins_t pol_mask;

  always_comb begin
    act_now = '0;
    use_now = '0;
    if (pwm_act) begin
      case (cfg_sh)
        CFG_SINGLE: begin
          use_now = 4'b1000;
          act_now.a = raw_wave;
        end
        CFG_HALF: begin
          use_now = 4'b1100;
          act_now.a = raw_wave && db_clear;
          act_now.b = !raw_wave && db_clear;
        end
        CFG_FWD: begin
          use_now = 4'b1111;
          act_now.a = 1'b1;
          act_now.d = raw_wave;
        end
        default: begin
          use_now = 4'b1111;
          act_now.c = 1'b1;
          act_now.b = raw_wave;
        end
      endcase
    end
  end

  // Active-low polarity: mode bit 1 inverts A and C, mode bit 0 inverts B and D.
  assign pol_mask = {pol_sh[1], pol_sh[0], pol_sh[1], pol_sh[0]};

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < LAG_DEPTH; i++) begin
        act_lag[i] <= '0;
        use_lag[i] <= '0;
        ovr_lag[i] <= 1'b0;
      end
    end else begin
      act_lag[0] <= act_now ^ pol_mask;
      use_lag[0] <= use_now;
      ovr_lag[0] <= (UNIT_INDEX == UNIT_THIRD) && pwm_act && cfg_sh[0];
      for (int i = 1; i < LAG_DEPTH; i++) begin
        act_lag[i] <= act_lag[i-1];
        use_lag[i] <= use_lag[i-1];
        ovr_lag[i] <= ovr_lag[i-1];
      end
    end
  end

  // Unused pins follow the port latch and its enable.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_data_out       <= '0;
      pin_oe_n_out       <= '1;
      unit4_override_out <= 1'b0;
    end else begin
      pin_data_out <= (act_lag[LAG_DEPTH-1] & use_lag[LAG_DEPTH-1])
                    | (port_data_in & ~use_lag[LAG_DEPTH-1]);
      pin_oe_n_out <= port_oe_n_in & ~use_lag[LAG_DEPTH-1];
      unit4_override_out <= ovr_lag[LAG_DEPTH-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare timers, special event trigger and flags.

  logic [15:0] tmr_sel;
  logic        cmp_match;
  logic        special;
  logic        ovf_first;
  logic        ovf_third;
  logic        rst_first;
  logic        rst_third;
  logic        has_special;

  assign has_special = (UNIT_INDEX == 1) || (UNIT_INDEX == UNIT_SEC);
  assign tmr_sel     = tctrl_reg.cmp_sel ? tmr_third_reg : tmr_first_reg;
  assign cmp_match   = cmp_mode && tcy_en && (tmr_sel == cmp_val_reg);
  assign special     = cmp_match && (ctrl_reg.mode == MODE_SPECIAL)
                     && has_special;
  assign rst_first   = special && !tctrl_reg.cmp_sel;
  assign rst_third   = special && tctrl_reg.cmp_sel;
  assign ovf_first   = tcy_en && !rst_first && (tmr_first_reg == 16'hFFFF);
  assign ovf_third   = tcy_en && !rst_third && (tmr_third_reg == 16'hFFFF);

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in)              tmr_first_reg <= 16'h0000;
    else if (wr_at(OFS_TMRF))  tmr_first_reg <= pwdata_in[15:0];
    else if (rst_first)        tmr_first_reg <= 16'h0000;
    else if (tcy_en)           tmr_first_reg <= tmr_first_reg + 16'h0001;
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in)              tmr_third_reg <= 16'h0000;
    else if (wr_at(OFS_TMRT))  tmr_third_reg <= pwdata_in[15:0];
    else if (rst_third)        tmr_third_reg <= 16'h0000;
    else if (tcy_en)           tmr_third_reg <= tmr_third_reg + 16'h0001;
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      special_trigger_out <= 1'b0;
      adc_start_out       <= 1'b0;
    end else begin
      special_trigger_out <= special;
      adc_start_out <= special && (UNIT_INDEX == UNIT_SEC) && adc_enable_in;
    end
  end

  // Write one to clear; a hardware set in the same cycle wins.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stat_reg <= 3'h0;
    end else begin
      stat_reg[ST_CMP]  <= cmp_match
                        || (stat_reg[ST_CMP] && !(wr_at(OFS_STAT) && pwdata_in[ST_CMP]));
      stat_reg[ST_TMRF] <= ovf_first
                        || (stat_reg[ST_TMRF] && !(wr_at(OFS_STAT) && pwdata_in[ST_TMRF]));
      stat_reg[ST_TMRT] <= ovf_third
                        || (stat_reg[ST_TMRT] && !(wr_at(OFS_STAT) && pwdata_in[ST_TMRT]));
    end
  end

endmodule : ecp_top
`default_nettype wire

/* include/ecp_pkg.sv */
// Constants, register map and types of the enhanced compare and PWM unit.
//
// Overview of operation
// - Compare mode 1011 raises an internal trigger pulse on compare match.
// - The trigger resets the selected 16-bit compare timer, making a period.
// - Unit two's trigger also starts a conversion while the converter is enabled.
// - On unit three, four and five, mode 1011 acts as mode 1010.
// - A trigger reset of a compare timer never sets that timer's flag.
// - Control bits 7:6 pick output configuration, bits 3:0 mode and polarity.
// - Configuration 00 single, 10 half-bridge, 01 forward, 11 reverse bridge.
// - Duty, its low two bits, configuration and polarity are double-buffered and load at the period boundary.
// - Dead-band working copy reloads at every duty boundary and every period boundary.
// - Enhanced outputs lag the plain waveform by one instruction cycle.
// - Period is limit plus one, times four oscillator periods, times prescale.
// - After timebase equals limit: clear timebase, set output unless 0%, copy duty.
// - The postscaler only makes an update tick, never changes PWM frequency.
// - Duty is 10 bits: write byte holds high eight, control 5:4 low two.
// - Duty writes allowed anytime, move to shadow at period match; shadow read-only in PWM mode.
// - Output clears when shadow plus latch equals timebase with two fine bits.
// - A duty longer than the period never clears the output.
// - Dead-band delay is a seven-bit count of instruction cycles.
// - PWM timebase is the second or fourth timer, chosen in timer control.
// - Unit three in quad mode overrides unit four's output pin.
// - Half-bridge drives PWM on output A and its complement on output B.
// - Forward keeps A active and modulates D; reverse keeps C, modulates B.
package ecp_pkg;

  localparam int  CLK_NS        = 100;
  localparam int  TCY_TOSC      = 4;
  localparam int  TCY_NS        = CLK_NS * TCY_TOSC;
  localparam int  TCY_CYCLES    = (TCY_NS + CLK_NS - 1) / CLK_NS;
  localparam int  LAG_DEPTH     = TCY_CYCLES - 1;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DUTYW  = 8'h04;
  localparam logic [7:0] OFS_DUTYS  = 8'h08;
  localparam logic [7:0] OFS_PERIOD = 8'h0C;
  localparam logic [7:0] OFS_DBAND  = 8'h10;
  localparam logic [7:0] OFS_TCTRL  = 8'h14;
  localparam logic [7:0] OFS_CMPV   = 8'h18;
  localparam logic [7:0] OFS_TMRF   = 8'h1C;
  localparam logic [7:0] OFS_TMRT   = 8'h20;
  localparam logic [7:0] OFS_STAT   = 8'h24;
  localparam logic [7:0] OFS_TBASE  = 8'h28;

  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [7:0] TCTRL_RST  = 8'h00;

  localparam logic [3:0] MODE_CMP_SWI = 4'hA;
  localparam logic [3:0] MODE_SPECIAL = 4'hB;
  localparam logic [1:0] MODE_PWM_PFX = 2'h3;
  localparam logic [1:0] CFG_SINGLE   = 2'h0;
  localparam logic [1:0] CFG_FWD      = 2'h1;
  localparam logic [1:0] CFG_HALF     = 2'h2;
  localparam logic [1:0] CFG_REV      = 2'h3;
  localparam logic [1:0] PRE_1        = 2'h0;
  localparam logic [1:0] PRE_4        = 2'h1;

  localparam int  TC_CMP_SEL = 0;
  localparam int  TC_PWM_SEL = 1;
  localparam int  ST_CMP     = 0;
  localparam int  ST_TMRF    = 1;
  localparam int  ST_TMRT    = 2;
  localparam int  UNIT_SEC   = 2;
  localparam int  UNIT_THIRD = 3;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } ecp_pins_t;

  typedef struct packed {
    logic [1:0] cfg;
    logic [1:0] dlsb;
    logic [3:0] mode;
  } ecp_ctrl_t;

  typedef struct packed {
    logic [3:0] post;
    logic [1:0] pre;
    logic       pwm_sel;
    logic       cmp_sel;
  } ecp_tctrl_t;

endpackage : ecp_pkg

/* sim/ecp_checker.sv */
// Port assertions for the enhanced compare and PWM unit.
`timescale 1ns/1ps
`default_nettype none
module ecp_checker import ecp_pkg::*; #(
  parameter int UNIT_INDEX = 1
) (
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire ecp_pins_t   port_data_in,
  input wire ecp_pins_t   port_oe_n_in,
  input wire ecp_pins_t   pin_data_out,
  input wire ecp_pins_t   pin_oe_n_out,
  input wire logic        unit4_override_out,
  input wire logic        special_trigger_out,
  input wire logic        adc_start_out,
  input wire logic        update_tick_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////////////////////////
  // Shadow of the control register and cycles since it was written.
  logic       ctrl_wr;
  logic [7:0] ctrl_reg;
  logic [5:0] calm_reg;
  ecp_ctrl_t  cur;
  assign ctrl_wr = psel_in && penable_in && pwrite_in && paddr_in == OFS_CTRL;
  assign cur     = ctrl_reg;
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) ctrl_reg <= CTRL_RST;
    else if (ctrl_wr) ctrl_reg <= pwdata_in[7:0];
  end
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) calm_reg <= 6'h00;
    else if (ctrl_wr) calm_reg <= 6'h00;
    else if (calm_reg != 6'h3F) calm_reg <= calm_reg + 6'h01;
  end
  ////////////////////////////////////////////////////////////
  a_ready_high:
    assert property (psel_in |-> pready_out) else $error("pready low in a transfer");
  a_unmapped_err:
    assert property (psel_in && !penable_in && paddr_in > OFS_TBASE |=> pslverr_out)
      else $error("no error on unmapped address");
  a_trig_pulse:
    assert property (special_trigger_out |=> !special_trigger_out)
      else $error("trigger longer than one cycle");
  a_trig_units:
    assert property (UNIT_INDEX > 2 |-> !special_trigger_out)
      else $error("trigger on a unit without one");
  a_adc_source:
    assert property (adc_start_out |-> special_trigger_out && UNIT_INDEX == UNIT_SEC)
      else $error("conversion start without unit two trigger");
  a_override_unit:
    assert property (unit4_override_out |-> UNIT_INDEX == UNIT_THIRD)
      else $error("override from a unit other than three");
  a_port_release:
    assert property (cur.mode == 4'h0 && calm_reg > 6'h03 |->
      pin_oe_n_out == port_oe_n_in && pin_data_out == port_data_in)
      else $error("pins not under port control while off");
  a_bridge_pair:
    assert property (cur.mode == 4'hC && cur.cfg != CFG_SINGLE && calm_reg == 6'h3F |->
      !(pin_data_out.a && pin_data_out.b)) else $error("both bridge sides active");
  a_tick_pulse:
    assert property (update_tick_out |=> !update_tick_out)
      else $error("update tick longer than one cycle");
  c_trigger: cover property (special_trigger_out && adc_start_out);
  c_tick: cover property (update_tick_out);
  c_error: cover property (pslverr_out);
endmodule : ecp_checker
`default_nettype wire

/* sim/ecp_bridge_model.sv */
// Bridge driver model: resolves pad levels from the unit's pin drive.
`timescale 1ns/1ps
`default_nettype none
module ecp_bridge_model import ecp_pkg::*; (
  input  wire ecp_pins_t pin_data_in,
  input  wire ecp_pins_t pin_oe_n_in,
  output var ecp_pins_t  pad_out
);
  // Released driver inputs sit on pull-downs, so an undriven pad reads low.
  assign pad_out = pin_data_in & ~pin_oe_n_in;
endmodule : ecp_bridge_model
`default_nettype wire

/* sim/ecp_top_test.sv */
// Self-checking bench for the enhanced compare and PWM unit.
`timescale 1ns/1ps
`default_nettype none
module ecp_top_test;
  import ecp_pkg::*;
  logic        clk, rstn, psel, pen, pwr, adc_en, pready, perr, ovr, trig, adc_go, tick, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  ecp_pins_t   pdat, poe, pin_d, pin_oe, pad;
  int          n_mismatch, check_count;
  int          cyc = 0;
  ecp_top #(.UNIT_INDEX(UNIT_SEC)) ecp_top_inst (
    .sys_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(perr), .adc_enable_in(adc_en),
    .port_data_in(pdat), .port_oe_n_in(poe), .pin_data_out(pin_d),
    .pin_oe_n_out(pin_oe), .unit4_override_out(ovr), .special_trigger_out(trig),
    .adc_start_out(adc_go), .update_tick_out(tick));
  ecp_bridge_model ecp_bridge_model_inst (
    .pin_data_in(pin_d), .pin_oe_n_in(pin_oe), .pad_out(pad));
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd   = prdata;
    err  = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rc
  // Loads one PWM setting, lets it settle, then counts pad high cycles.
  task automatic pwm_case(input logic [7:0] ctrl, duty, db, tc, input int win,
                          input int ea, eb, ec, ed, et, input ecp_pins_t eoe);
    int ca, cb, cc, cd, ct;
    wr(OFS_TCTRL, {24'h0, tc});
    wr(OFS_PERIOD, 32'h3);
    wr(OFS_DBAND, {24'h0, db});
    wr(OFS_DUTYW, {24'h0, duty});
    wr(OFS_CTRL, {24'h0, ctrl});
    {ca, cb, cc, cd, ct} = '0;
    repeat (win) @(negedge clk);
    repeat (win) begin
      @(negedge clk);
      ca += (pad.a === 1'b1);
      cb += (pad.b === 1'b1);
      cc += (pad.c === 1'b1);
      cd += (pad.d === 1'b1);
      ct += (tick === 1'b1);
    end
    check("pad a", ca, ea);
    check("pad b", cb, eb);
    check("pad c", cc, ec);
    check("pad d", cd, ed);
    check("ticks", ct, et);
    check("pin enables", pin_oe, eoe);
    check("override", ovr, 1'b0);
    $display("pwm case %0h done", ctrl);
  endtask : pwm_case
  task automatic wait_trig(input logic exp_adc);
    int n;
    n = 0;
    while (trig !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check("trigger seen", n < 300, 1'b1);
    check("adc start", adc_go, exp_adc);
    @(negedge clk);
  endtask : wait_trig
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    {psel, pen, pwr, adc_en} = 4'b0001;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    pdat        = 4'b0110;
    poe         = 4'b0001;
    n_mismatch  = 0;
    check_count = 0;
    rstn        = 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rc("control reset", OFS_CTRL, {24'h0, CTRL_RST});
    rc("period reset", OFS_PERIOD, {24'h0, PERIOD_RST});
    // Shorten the period before the timebase can run past the new limit.
    wr(OFS_PERIOD, 32'h3);
    rc("timer ctrl reset", OFS_TCTRL, {24'h0, TCTRL_RST});
    rc("unmapped data", 8'h30, 32'h0);
    check("unmapped error", err, 1'b1);
    $display("register test done");
    pwm_case(8'h0C, 8'h01, 8'h0, 8'h00, 64, 16, 64, 64, 0, 4, 4'b0001);
    rc("duty shadow", OFS_DUTYS, 32'h1);
    wr(OFS_DUTYS, 32'h55);
    rc("shadow read only", OFS_DUTYS, 32'h1);
    pwm_case(8'h2C, 8'h01, 8'h0, 8'h00, 64, 24, 64, 64, 0, 4, 4'b0001);
    pwm_case(8'h0C, 8'h00, 8'h0, 8'h00, 64, 0, 64, 64, 0, 4, 4'b0001);
    pwm_case(8'h0C, 8'hFF, 8'h0, 8'h00, 64, 64, 64, 64, 0, 4, 4'b0001);
    pwm_case(8'h0E, 8'h01, 8'h0, 8'h00, 64, 48, 64, 64, 0, 4, 4'b0001);
    pwm_case(8'h8C, 8'h02, 8'h0, 8'h00, 64, 32, 32, 64, 0, 4, 4'b0001);
    pwm_case(8'h8C, 8'h02, 8'h1, 8'h00, 64, 16, 16, 64, 0, 4, 4'b0001);
    pwm_case(8'h4C, 8'h01, 8'h0, 8'h00, 64, 64, 0, 0, 16, 4, 4'b0000);
    pwm_case(8'hCC, 8'h01, 8'h0, 8'h00, 64, 0, 16, 64, 0, 4, 4'b0000);
    pwm_case(8'h0C, 8'h01, 8'h0, 8'h02, 64, 16, 64, 64, 0, 4, 4'b0001);
    pwm_case(8'h0C, 8'h02, 8'h0, 8'h14, 128, 64, 128, 128, 0, 1, 4'b0001);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_TCTRL, 32'h0);
    wr(OFS_CMPV, 32'h14);
    wr(OFS_TMRF, 32'h0);
    wr(OFS_STAT, 32'h7);
    wr(OFS_CTRL, {28'h0, MODE_SPECIAL});
    wait_trig(1'b1);
    rc("status first", OFS_STAT, 32'h1);
    apb(1'b0, OFS_TMRF, 32'h0);
    check("first timer reset", rd < 32'h14, 1'b1);
    adc_en <= 1'b0;
    // Match at the top count, so a trigger reset stands where an overflow would.
    wr(OFS_CMPV, 32'hFFFF);
    wr(OFS_TCTRL, 32'h1);
    wr(OFS_TMRT, 32'hFFEC);
    wr(OFS_STAT, 32'h7);
    wait_trig(1'b0);
    rc("status third", OFS_STAT, 32'h1);
    apb(1'b0, OFS_TMRT, 32'h0);
    check("third timer reset", rd < 32'h14, 1'b1);
    $display("compare test done");
    complete_run();
  end
endmodule : ecp_top_test
bind ecp_top ecp_checker #(.UNIT_INDEX(UNIT_INDEX)) ecp_checker_inst (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .port_data_in(port_data_in), .port_oe_n_in(port_oe_n_in),
  .pin_data_out(pin_data_out), .pin_oe_n_out(pin_oe_n_out),
  .unit4_override_out(unit4_override_out), .special_trigger_out(special_trigger_out),
  .adc_start_out(adc_start_out), .update_tick_out(update_tick_out));
`default_nettype wire
